// File: inc/ptrr_consts.svh
// Constants of the posted timer read resynchronizer
//---------------------------------------------------------------
// Overview of operation
// - Posted reads right after interface clock restart may be stale.
// - Non-posted timer reads return the live value at once.
// - Watchdog count reads share the posted stale-after-wakeup hazard.
// - Watchdog values are always read through the posted path.
// - Sync timer count and revision are always posted, same wakeup hazard.
//---------------------------------------------------------------
`ifndef PTRR_CONSTS_SVH
`define PTRR_CONSTS_SVH

//---------------------------------------------------------------
// Read selects
//---------------------------------------------------------------
`define PTRR_SEL_TIMER 3'h0
`define PTRR_SEL_CAP1 3'h1
`define PTRR_SEL_CAP2 3'h2
`define PTRR_SEL_WDOG 3'h3
`define PTRR_SEL_SYNC 3'h4
`define PTRR_SEL_REV 3'h5
`define PTRR_NUM_SRC 6

//---------------------------------------------------------------
// Clock rates and wakeup wait
//---------------------------------------------------------------
`define PTRR_IF_DIV 4
`define PTRR_FUNC_DIV 16
`define PTRR_WAIT_IF_CYC 2'h2
`define PTRR_WAIT_FUNC_CYC 1

//---------------------------------------------------------------
// Reset values
//---------------------------------------------------------------
`define PTRR_CNT_RST 'h0
`define PTRR_REVISION_DEF 32'h0000_00a5

`endif

// File: inc/ptrr_pkg.sv
// Types of the posted timer read resynchronizer
package ptrr_pkg;

	typedef logic [2:0] ptrr_sel_t;

	typedef enum logic [1:0]
	{
		PTRR_STOPPED = 2'b00,
		PTRR_WAIT_FUNC = 2'b01,
		PTRR_WAIT_IF = 2'b11,
		PTRR_READY = 2'b10
	} ptrr_wake_t;

endpackage

// File: hw/ptrr_tick_div.sv
// Enable pulse divider
`timescale 1ns/100ps
module ptrr_tick_div
#(
	parameter int DIV = 4
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic enable,
	output logic tick
);
	import ptrr_pkg::*;

	localparam int CW = $clog2(DIV) + 1;

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic tick;
	} ptrr_div_st_t;

	ptrr_div_st_t s_r;
	ptrr_div_st_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (enable)
		begin
			if (s_r.cnt == CW'(DIV - 1))
			begin
				s_nxt.cnt = '0;
				s_nxt.tick = 1'b1;
			end
			else
				s_nxt.cnt = s_r.cnt + CW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;

endmodule // ptrr_tick_div

// File: hw/ptrr_read_resync.sv
// Timer value read path with posted resynchronization
`timescale 1ns/100ps
`include "ptrr_consts.svh"
module ptrr_read_resync
#(
	parameter int W = 32,
	parameter logic [31:0] REVISION = `PTRR_REVISION_DEF, // Arbitrary value
	parameter int IF_DIV = `PTRR_IF_DIV,
	parameter int FUNC_DIV = `PTRR_FUNC_DIV
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ifClkRun,
	input wire logic postedMode,
	input wire logic timerEnable,
	input wire logic captureFirstEvt,
	input wire logic captureSecondEvt,
	input wire logic readReq,
	input wire ptrr_pkg::ptrr_sel_t readSel,
	output logic [W-1:0] readData,
	output logic readAck,
	output logic readFresh,
	output logic waitDone
);
	import ptrr_pkg::*;

	localparam int NS = `PTRR_NUM_SRC;

	typedef struct packed
	{
		logic [W-1:0] timerCnt;
		logic [W-1:0] capFirst;
		logic [W-1:0] capSecond;
		logic [W-1:0] wdogCnt;
		logic [W-1:0] syncCnt;
		logic [NS-1:0][W-1:0] funcStage;
		logic [NS-1:0][W-1:0] ifStage;
		logic [NS-1:0][W-1:0] shadow;
		ptrr_wake_t wake;
		logic [1:0] ifCnt;
		logic [1:0] ifSeen;
		logic funcSeen;
		logic [W-1:0] readData;
		logic readAck;
		logic readFresh;
		logic waitDone;
	} ptrr_st_t;

	ptrr_st_t s_r;
	ptrr_st_t s_nxt;
	logic funcTick;
	logic ifTick;
	logic [NS-1:0][W-1:0] live;
	logic [W-1:0] liveMux;
	logic [W-1:0] shadowMux;
	logic usePosted;
	logic readTake;

	//---------------------------------------------------------------
	// Clock rate enables
	//---------------------------------------------------------------
	ptrr_tick_div #(.DIV(FUNC_DIV)) uFuncDiv
	(
		.clk(clk),
		.reset(reset),
		.enable(1'b1),
		.tick(funcTick)
	);

	ptrr_tick_div #(.DIV(IF_DIV)) uIfDiv
	(
		.clk(clk),
		.reset(reset),
		.enable(ifClkRun),
		.tick(ifTick)
	);

	function automatic logic sel_posted(input ptrr_sel_t sel, input logic pm);
		sel_posted = pm || (sel >= `PTRR_SEL_WDOG);
	endfunction

	//---------------------------------------------------------------
	// Read multiplexers
	//---------------------------------------------------------------
	always_comb
	begin
		live[`PTRR_SEL_TIMER] = s_r.timerCnt;
		live[`PTRR_SEL_CAP1] = s_r.capFirst;
		live[`PTRR_SEL_CAP2] = s_r.capSecond;
		live[`PTRR_SEL_WDOG] = s_r.wdogCnt;
		live[`PTRR_SEL_SYNC] = s_r.syncCnt;
		live[`PTRR_SEL_REV] = W'(REVISION);
		liveMux = '0;
		shadowMux = '0;
		if (readSel < 3'(NS))
		begin
			liveMux = live[readSel];
			shadowMux = s_r.shadow[readSel];
		end
		usePosted = sel_posted(readSel, postedMode);
		readTake = readReq && ifClkRun;
	end

	//---------------------------------------------------------------
	// Next state
	//---------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.readAck = 1'b0;
		if (captureFirstEvt)
			s_nxt.capFirst = s_r.timerCnt;
		if (captureSecondEvt)
			s_nxt.capSecond = s_r.timerCnt;
		if (funcTick)
		begin
			if (timerEnable)
				s_nxt.timerCnt = s_r.timerCnt + W'(1);
			s_nxt.wdogCnt = s_r.wdogCnt + W'(1);
			s_nxt.syncCnt = s_r.syncCnt + W'(1);
			s_nxt.funcStage = live;
			s_nxt.funcSeen = 1'b1;
		end
		// Two interface stages, frozen while that clock is stopped
		if (ifTick)
		begin
			s_nxt.ifStage = s_r.funcStage;
			s_nxt.shadow = s_r.ifStage;
			if (s_r.ifSeen != 2'h3)
				s_nxt.ifSeen = s_r.ifSeen + 2'h1;
		end
		case (s_r.wake)
			PTRR_STOPPED:
			begin
				s_nxt.funcSeen = 1'b0;
				s_nxt.ifSeen = 2'h0;
				if (ifClkRun)
					s_nxt.wake = PTRR_WAIT_FUNC;
			end
			PTRR_WAIT_FUNC:
			begin
				s_nxt.ifCnt = 2'h0;
				if (funcTick)
					s_nxt.wake = PTRR_WAIT_IF;
			end
			PTRR_WAIT_IF:
			begin
				if (ifTick)
					s_nxt.ifCnt = s_r.ifCnt + 2'h1;
				if (ifTick && s_r.ifCnt + 2'h1 == `PTRR_WAIT_IF_CYC)
					s_nxt.wake = PTRR_READY;
			end
			PTRR_READY:
				s_nxt.wake = PTRR_READY;
			default:
				s_nxt.wake = PTRR_STOPPED;
		endcase
		if (!ifClkRun)
			s_nxt.wake = PTRR_STOPPED;
		s_nxt.waitDone = (s_nxt.wake == PTRR_READY);
		if (readTake)
		begin
			s_nxt.readAck = 1'b1;
			if (usePosted)
			begin
				s_nxt.readData = shadowMux;
				s_nxt.readFresh = (s_r.wake == PTRR_READY);
			end
			else
			begin
				s_nxt.readData = liveMux;
				s_nxt.readFresh = 1'b1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			s_r <= '0;
			s_r.wake <= PTRR_STOPPED;
		end
		else
			s_r <= s_nxt;
	end

	assign readData = s_r.readData;
	assign readAck = s_r.readAck;
	assign readFresh = s_r.readFresh;
	assign waitDone = s_r.waitDone;

	//---------------------------------------------------------------
	// Checks
	//---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence wakeStart;
		$rose(ifClkRun);
	endsequence

	sequence postedRead;
		readTake && usePosted;
	endsequence

	a_nonposted_live: assert property
		(readTake && !usePosted |=> readAck && readFresh
			&& readData == $past(liveMux))
		else $error("Non-posted read not live");

	a_wdog_posted: assert property
		(readTake && readSel == `PTRR_SEL_WDOG |=>
			readData == $past(shadowMux))
		else $error("Watchdog read bypassed posted path");

	a_wdog_always: assert property
		(readTake && readSel == `PTRR_SEL_WDOG && !postedMode |=>
			readFresh == $past(waitDone))
		else $error("Watchdog read treated as non-posted");

	a_sync_posted: assert property
		(readTake && readSel >= `PTRR_SEL_SYNC && readSel <= `PTRR_SEL_REV
			|=> readData == $past(shadowMux))
		else $error("Sync timer read bypassed posted path");

	a_stale_wake: assert property
		(wakeStart ##0 postedRead |=> readAck && !readFresh)
		else $error("Posted read fresh right at wakeup");

	a_wait_held: assert property
		(wakeStart |-> !waitDone [*3])
		else $error("Wait ended too soon after wakeup");

	a_wait_length: assert property
		($rose(waitDone) |-> s_r.funcSeen && s_r.ifSeen >= 2'h2)
		else $error("Wait shorter than two plus one cycles");

	a_fresh_ready: assert property
		(postedRead ##0 waitDone |=> readFresh
			&& readData == $past(shadowMux))
		else $error("Posted read after wait not fresh");

	a_stop_clears: assert property
		(!ifClkRun |=> !waitDone)
		else $error("Wait state kept while clock stopped");

endmodule // ptrr_read_resync

// File: tb/posted_timer_read_resync_test.sv
// Self-checking bench of the posted timer read resynchronizer
`timescale 1ns/100ps
`include "ptrr_consts.svh"
module posted_timer_read_resync_test;
	import ptrr_pkg::*;
	typedef struct {logic [31:0] d; logic f; logic m; logic fm;} ptrr_note_t;
	logic clk, reset, ifClkRun, postedMode, timerEnable, readReq;
	logic captureFirstEvt, captureSecondEvt, readAck, readFresh, waitDone;
	ptrr_sel_t readSel;
	logic [31:0] readData, rnd;
	int nMismatch, checked, cycles;
	ptrr_note_t notes[$];
	ptrr_note_t cur;
	ptrr_sel_t firstSel[3] = '{3'h4, 3'h3, 3'h5};

	ptrr_read_resync #(.IF_DIV(2), .FUNC_DIV(2)) u_ptrr_read_resync
	(
		.clk(clk), .reset(reset), .ifClkRun(ifClkRun),
		.postedMode(postedMode), .timerEnable(timerEnable),
		.captureFirstEvt(captureFirstEvt),
		.captureSecondEvt(captureSecondEvt), .readReq(readReq),
		.readSel(readSel), .readData(readData), .readAck(readAck),
		.readFresh(readFresh), .waitDone(waitDone)
	);

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want)
		begin
			nMismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic close_out;
		if (nMismatch == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Request one read with the interface clock running, note the answer
	task automatic issue(input ptrr_sel_t s, input logic f);
		@(posedge clk);
		ifClkRun <= 1'b1;
		readReq <= 1'b1;
		readSel <= s;
		notes.push_back('{(s == 3'h5) ? `PTRR_REVISION_DEF : 32'h0, f,
			s != 3'h3 && s != 3'h4, s < 3'h6});
	endtask

	task automatic idle(input int n);
		@(posedge clk);
		readReq <= 1'b0;
		repeat (n) @(posedge clk);
	endtask

	//---------------------------------------------------------------
	// Clock and watchdog
	//---------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			nMismatch++;
			close_out();
		end
	end

	//---------------------------------------------------------------
	// Answer monitor
	//---------------------------------------------------------------
	always @(posedge clk)
		if (readAck === 1'b1)
		begin
			if (notes.size() == 0)
				check(32'h1, 32'h0);
			else
			begin
				cur = notes.pop_front();
				if (cur.fm)
					check(readFresh, cur.f);
				if (cur.m)
					check(readData, cur.d);
			end
		end

	//---------------------------------------------------------------
	// Stimulus
	//---------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		{ifClkRun, postedMode, timerEnable, readReq} = 4'h4;
		{captureFirstEvt, captureSecondEvt} = 2'h0;
		readSel = 3'h0;
		rnd = 32'he226;
		nMismatch = 0;
		checked = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		// Stopped interface ignores a read
		@(posedge clk);
		readReq <= 1'b1;
		readSel <= 3'h5;
		idle(3);
		check(waitDone, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			// Wake and read at once, then after the wait
			postedMode <= (k != 1);
			issue(firstSel[k], 1'b0);
			issue(k[2:0], k == 1);
			idle(30);
			check(waitDone, 1'b1);
			for (int s = 0; s < 8; s++)
				issue(s[2:0], 1'b1);
			idle(2);
			ifClkRun <= 1'b0;
			repeat (3) @(posedge clk);
			check(waitDone, 1'b0);
		end
		ifClkRun <= 1'b1;
		repeat (30) @(posedge clk);
		// Random modes, capture pulses and selects
		repeat (40)
		begin
			rnd = xs(rnd);
			postedMode <= rnd[0];
			captureFirstEvt <= rnd[1];
			captureSecondEvt <= rnd[2];
			issue(rnd[5:3], 1'b1);
		end
		{captureFirstEvt, captureSecondEvt} <= 2'h0;
		idle(5);
		check(notes.size(), 32'h0);
		close_out();
	end
endmodule // posted_timer_read_resync_test
